// [pkg/cad_defs.svh]
// Address layout constants for configuration access decoding
`ifndef CAD_DEFS_SVH
`define CAD_DEFS_SVH

// ----------------------------------------------------------------------
// Packet address prefixes
// ----------------------------------------------------------------------
`define CAD_PFX_LSB 24
`define CAD_PFX_T0 40'h00000000FDFE
`define CAD_PFX_T1 40'h00000000FDFF
`define CAD_XPFX_LSB 28
`define CAD_XPFX_T0 36'h0000000FE0
`define CAD_XPFX_T1 36'h0000000FE1

// ----------------------------------------------------------------------
// Packet address fields
// ----------------------------------------------------------------------
`define CAD_UREG_LSB 24
`define CAD_BUS_LSB 16
`define CAD_DEV_LSB 11
`define CAD_FN_LSB 8
`define CAD_REG_LSB 2

// ----------------------------------------------------------------------
// Flat software address fields
// ----------------------------------------------------------------------
`define CAD_FBUS_LSB 20
`define CAD_FDEV_LSB 15
`define CAD_FFN_LSB 12
`define CAD_FREG_LSB 2

// ----------------------------------------------------------------------
// Reset values and fixed numbers
// ----------------------------------------------------------------------
`define CAD_HOST_UNIT 5'h00
`define CAD_FUNC_HDR 3'h0
`define CAD_BUS_RST 8'h00

`endif

// [pkg/cad_pkg.sv]
// Types shared by the configuration access decoder
`default_nettype none
package cad_pkg;

  // ----------------------------------------------------------------------
  // Incoming sized request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [63:0] addr;
    logic write;
    logic posted;
    logic [3:0] len_dw_m1;
    logic upstream;
    logic [4:0] src_unit;
  } cad_req_type;

  // ----------------------------------------------------------------------
  // Static configuration of this end
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] base_unit_identifier;
    logic [5:0] unit_count;
    logic [31:0] impl_mask;
    logic [4:0] host_dev_num;
    logic secondary_side;
    logic upstream_cfg_en;
    logic [7:0] chain_bus;
  } cad_cfg_type;

  typedef enum logic [2:0] {
    CAD_KIND_NONE, CAD_KIND_T0, CAD_KIND_T1, CAD_KIND_XT0, CAD_KIND_XT1
  } cad_kind_type;

  typedef enum logic [2:0] {
    CAD_ACT_NONE, CAD_ACT_ACCEPT, CAD_ACT_FORWARD, CAD_ACT_REFLECT,
    CAD_ACT_ABORT, CAD_ACT_UNCLAIMED, CAD_ACT_MESSAGE, CAD_ACT_DROP
  } cad_act_type;

  // ----------------------------------------------------------------------
  // Decode result
  // ----------------------------------------------------------------------
  typedef struct packed {
    cad_act_type act;
    cad_kind_type kind;
    logic [7:0] bus;
    logic [4:0] dev;
    logic [2:0] fn;
    logic [9:0] regnum;
    logic write;
    logic [63:0] new_addr;
  } cad_res_type;

  typedef struct packed {
    logic [63:0] addr;
    logic write;
    logic ext;
  } cad_pkt_type;

endpackage : cad_pkg
`default_nettype wire

// [core/cad_flat_xlate.sv]
// Flat software configuration address to packet address translation
`default_nettype none
`include "cad_defs.svh"
module cad_flat_xlate (
  // Flat address and local chain
  input wire logic [27:0] flat_addr,
  input wire logic [7:0] chain_bus,
  // Packet address
  output logic [63:0] pkt_addr,
  output logic pkt_ext
);
  import cad_pkg::*;

  wire [7:0] f_bus = flat_addr[`CAD_FBUS_LSB +: 8];
  wire [4:0] f_dev = flat_addr[`CAD_FDEV_LSB +: 5];
  wire [2:0] f_fn = flat_addr[`CAD_FFN_LSB +: 3];
  wire [9:0] f_reg = flat_addr[`CAD_FREG_LSB +: 10];
  wire local_bus = (f_bus == chain_bus);
  // Older targets cannot decode the extended form, so the low space
  // goes out in the regular format
  wire need_ext = (f_reg[9:6] != 4'h0);
  wire [23:0] low_fields = {f_bus, f_dev, f_fn, f_reg[5:0], 2'b00};
  wire [39:0] reg_pfx = local_bus ? `CAD_PFX_T0 : `CAD_PFX_T1;
  wire [35:0] ext_pfx = local_bus ? `CAD_XPFX_T0 : `CAD_XPFX_T1;

  assign pkt_ext = need_ext;
  assign pkt_addr = need_ext ? {ext_pfx, f_reg[9:6], low_fields}
                             : {reg_pfx, low_fields};

endmodule : cad_flat_xlate
`default_nettype wire

// [core/cad_config_decode.sv]
// Configuration access decoder for a chain device or host bridge
//
// Overview of operation
// - Type 0 address: prefix 63:24, bus, device, function, dword register.
// - Only host bridges issue Type 0, so it always travels downstream.
// - Device compares the Type 0 device field against its own device numbers.
// - Double-ended host answers secondary Type 0 at its programmed device.
// - Type 1 address: own prefix in 63:24, same field layout as Type 0.
// - Devices may issue Type 1 peer configuration; hosts may accept it.
// - Host converts local-chain upstream Type 1 to Type 0, accepts own target.
// - Host without upstream configuration support aborts such requests.
// - Extended Type 0: prefix 63:28, upper register 27:24, rest as Type 0.
// - Extended Type 1: same layout, its own prefix in 63:28.
// - Nonposted extended reach registers; posted extended carry messages.
// - Basic functions stay reachable without extended configuration accesses.
// - Every implemented device number has function 0 with a header.
// - Five-bit unit identifiers; base identifier device space always exists.
// - Unimplemented device numbers are not claimed; they master-abort.
// - Host registers on bus 0 sit in the top device numbers, never 0.
// - Unit identifier 0 belongs to the host only.
// - Host translates a flat software address into the packet format.
`default_nettype none
`include "cad_defs.svh"
module cad_config_decode #(
  parameter bit IS_HOST = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Static configuration
  input wire cad_pkg::cad_cfg_type cfg,
  // Received sized request
  input wire logic req_valid,
  input wire cad_pkg::cad_req_type req,
  // Flat software access, host only
  input wire logic sw_valid,
  input wire logic [27:0] sw_addr,
  input wire logic sw_write,
  // Decode result
  output logic res_valid_q,
  output cad_pkg::cad_res_type res_q,
  // Translated packet, host only
  output logic pkt_valid_q,
  output cad_pkg::cad_pkt_type pkt_q,
  // Status
  output logic [7:0] bus_num_q,
  output logic cfg_bad_q
);
  import cad_pkg::*;

  // ----------------------------------------------------------------------
  // Prefix and field extraction
  // ----------------------------------------------------------------------
  wire [39:0] pfx = req.addr[63:`CAD_PFX_LSB];
  wire [35:0] xpfx = req.addr[63:`CAD_XPFX_LSB];
  wire hit_t0 = (pfx == `CAD_PFX_T0);
  wire hit_t1 = (pfx == `CAD_PFX_T1);
  wire hit_xt0 = (xpfx == `CAD_XPFX_T0);
  wire hit_xt1 = (xpfx == `CAD_XPFX_T1);
  wire is_cfg = hit_t0 | hit_t1 | hit_xt0 | hit_xt1;
  wire is_ext = hit_xt0 | hit_xt1;
  wire is_type0 = hit_t0 | hit_xt0;

  wire [7:0] f_bus = req.addr[`CAD_BUS_LSB +: 8];
  wire [4:0] f_dev = req.addr[`CAD_DEV_LSB +: 5];
  wire [2:0] f_fn = req.addr[`CAD_FN_LSB +: 3];
  wire [3:0] f_ureg = is_ext ? req.addr[`CAD_UREG_LSB +: 4] : 4'h0;
  wire [9:0] f_reg = {f_ureg, req.addr[`CAD_REG_LSB +: 6]};

  cad_kind_type kind;
  assign kind = hit_t0 ? CAD_KIND_T0 :
                hit_t1 ? CAD_KIND_T1 :
                hit_xt0 ? CAD_KIND_XT0 :
                hit_xt1 ? CAD_KIND_XT1 : CAD_KIND_NONE;

  // ----------------------------------------------------------------------
  // Request shape checks
  // ----------------------------------------------------------------------
  // Oversized or posted register writes have no defined effect, so they
  // are dropped rather than half-applied
  wire too_long = (req.len_dw_m1 != 4'h0);
  wire posted_wr = req.write & req.posted;
  wire is_message = is_ext & posted_wr;
  wire bad_posted = posted_wr & ~is_ext;
  // A Type 0 travelling upstream cannot come from a host
  wire t0_wrong_dir = is_type0 & (req.upstream | (req.src_unit != `CAD_HOST_UNIT));

  // ----------------------------------------------------------------------
  // Device number ownership
  // ----------------------------------------------------------------------
  wire [5:0] dev_w = {1'b0, f_dev};
  wire [5:0] base_w = {1'b0, cfg.base_unit_identifier};
  wire [5:0] top_w = 6'(base_w + cfg.unit_count);
  // Unit identifier 0 is the host's, a device with base 0 is misconfigured
  wire base_ok = (cfg.base_unit_identifier != `CAD_HOST_UNIT);
  wire dev_owned = (dev_w >= base_w) && (dev_w < top_w);
  wire [31:0] base_bit = 32'h00000001 << cfg.base_unit_identifier;
  wire [31:0] impl_eff = cfg.impl_mask | base_bit;
  wire dev_impl = dev_owned & impl_eff[f_dev] & base_ok;

  // ----------------------------------------------------------------------
  // Host ownership
  // ----------------------------------------------------------------------
  // The host's own spaces start at host_dev_num and run to the top;
  // device 0 is never taken so the chain can still be enumerated
  wire host_dev_ok = (cfg.host_dev_num != 5'h00);
  wire host_self = host_dev_ok & (f_dev >= cfg.host_dev_num);
  wire on_chain = (f_bus == cfg.chain_bus);
  wire sec_t0_hit = cfg.secondary_side & host_dev_ok & (f_dev == cfg.host_dev_num);

  // Reflected Type 0 keeps every field, only the prefix changes
  wire [63:0] reflect_addr = is_ext
    ? {`CAD_XPFX_T0, req.addr[`CAD_XPFX_LSB-1:0]}
    : {`CAD_PFX_T0, req.addr[`CAD_PFX_LSB-1:0]};

  // ----------------------------------------------------------------------
  // Action selection
  // ----------------------------------------------------------------------
  cad_act_type dev_act;
  cad_act_type host_act;
  cad_act_type act;

  always_comb begin
    if (is_type0) begin
      dev_act = dev_impl ? CAD_ACT_ACCEPT : CAD_ACT_UNCLAIMED;
    end else begin
      dev_act = CAD_ACT_FORWARD;
    end
  end

  always_comb begin
    if (is_type0) begin
      host_act = (~req.upstream & sec_t0_hit) ? CAD_ACT_ACCEPT : CAD_ACT_UNCLAIMED;
    end else if (!req.upstream) begin
      host_act = CAD_ACT_FORWARD;
    end else if (!cfg.upstream_cfg_en) begin
      host_act = CAD_ACT_ABORT;
    end else if (on_chain && host_self) begin
      host_act = CAD_ACT_ACCEPT;
    end else if (on_chain) begin
      host_act = CAD_ACT_REFLECT;
    end else begin
      host_act = CAD_ACT_ABORT;
    end
  end

  always_comb begin
    if (!is_cfg) begin
      act = CAD_ACT_NONE;
    end else if (is_message) begin
      act = CAD_ACT_MESSAGE;
    end else if (too_long || bad_posted) begin
      act = CAD_ACT_DROP;
    end else if (IS_HOST) begin
      act = host_act;
    end else if (t0_wrong_dir) begin
      act = CAD_ACT_DROP;
    end else begin
      act = dev_act;
    end
  end

  cad_res_type res_d;
  always_comb begin
    res_d.act = act;
    res_d.kind = kind;
    res_d.bus = f_bus;
    res_d.dev = f_dev;
    res_d.fn = f_fn;
    res_d.regnum = f_reg;
    res_d.write = req.write;
    res_d.new_addr = (act == CAD_ACT_REFLECT) ? reflect_addr : req.addr;
  end

  // ----------------------------------------------------------------------
  // Bus number learned from accepted Type 0 accesses
  // ----------------------------------------------------------------------
  // Software assigns the number; the device only mirrors what the
  // host transmits so device messages can carry it
  wire learn_bus = req_valid & (act == CAD_ACT_ACCEPT) & is_type0;
  wire [7:0] bus_num_d = learn_bus ? f_bus : bus_num_q;
  // Static configuration sanity: device needs a nonzero base, host a top space
  wire cfg_bad_d = IS_HOST ? ~host_dev_ok : ~base_ok;

  // ----------------------------------------------------------------------
  // Flat software address translation, host only
  // ----------------------------------------------------------------------
  logic [63:0] xl_addr;
  logic xl_ext;

  cad_flat_xlate cad_flat_xlate_inst (
    .flat_addr(sw_addr),
    .chain_bus(cfg.chain_bus),
    .pkt_addr(xl_addr),
    .pkt_ext(xl_ext)
  );

  wire pkt_valid_d = IS_HOST & sw_valid;
  cad_pkt_type pkt_d;
  always_comb begin
    pkt_d.addr = xl_addr;
    pkt_d.write = sw_write;
    pkt_d.ext = xl_ext;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      pkt_valid_q <= 1'b0;
    end else begin
      res_valid_q <= req_valid;
      pkt_valid_q <= pkt_valid_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      res_q <= '0;
      pkt_q <= '0;
    end else begin
      if (req_valid) begin
        res_q <= res_d;
      end
      if (pkt_valid_d) begin
        pkt_q <= pkt_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_num_q <= `CAD_BUS_RST;
      cfg_bad_q <= 1'b0;
    end else begin
      bus_num_q <= bus_num_d;
      cfg_bad_q <= cfg_bad_d;
    end
  end

endmodule : cad_config_decode
`default_nettype wire

// [verif/cad_config_decode_asserts.sv]
// Concurrent checks on the configuration access decoder ports
`default_nettype none
`include "cad_defs.svh"
module cad_config_decode_asserts #(
  parameter bit IS_HOST = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched inputs
  input wire cad_pkg::cad_cfg_type cfg,
  input wire logic req_valid,
  input wire cad_pkg::cad_req_type req,
  input wire logic sw_valid,
  input wire logic [27:0] sw_addr,
  // Watched outputs
  input wire logic res_valid_q,
  input wire cad_pkg::cad_res_type res_q,
  input wire logic pkt_valid_q,
  input wire cad_pkg::cad_pkt_type pkt_q
);
  import cad_pkg::*;
  wire t0 = req.addr[63:24] == `CAD_PFX_T0;
  wire t1 = req.addr[63:24] == `CAD_PFX_T1;
  wire x0 = req.addr[63:28] == `CAD_XPFX_T0;
  wire x1 = req.addr[63:28] == `CAD_XPFX_T1;
  wire any_cfg = t0 | t1 | x0 | x1;
  wire plain = req_valid && req.len_dw_m1 == 4'h0 && !req.posted && !req.upstream;
  wire [5:0] lim = {1'b0, cfg.base_unit_identifier} + cfg.unit_count;
  wire out_rng = {1'b0, req.addr[15:11]} >= lim || req.addr[15:11] < cfg.base_unit_identifier;
  wire up_t1 = IS_HOST && req_valid && t1 && req.upstream && req.len_dw_m1 == 4'h0 && !req.posted;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_nonprefix_none: assert property (req_valid && !any_cfg |=> res_q.act == CAD_ACT_NONE)
    else $error("non configuration address not passed as normal request");
  a_t0_fields: assert property (plain && t0 |=> res_valid_q && res_q.kind == CAD_KIND_T0
    && res_q.dev == $past(req.addr[15:11]) && res_q.bus == $past(req.addr[23:16]))
    else $error("type 0 fields decoded wrongly");
  a_t1_fields: assert property (plain && t1 |=> res_q.kind == CAD_KIND_T1
    && res_q.fn == $past(req.addr[10:8]) && res_q.write == $past(req.write))
    else $error("type 1 fields decoded wrongly");
  a_ext_regnum: assert property (plain && x0 |=> res_q.kind == CAD_KIND_XT0
    && res_q.regnum == {$past(req.addr[27:24]), $past(req.addr[7:2])})
    else $error("extended register number wrong");
  a_xt1_kind: assert property (plain && x1 |=> res_q.kind == CAD_KIND_XT1)
    else $error("extended type 1 not recognised");
  a_posted_msg: assert property (req_valid && (x0 || x1) && req.write && req.posted
    |=> res_q.act == CAD_ACT_MESSAGE) else $error("posted extended write not a message");
  a_long_drop: assert property (req_valid && any_cfg && req.len_dw_m1 != 4'h0 && !req.posted
    |=> res_q.act == CAD_ACT_DROP) else $error("long configuration access not dropped");
  a_posted_drop: assert property (req_valid && (t0 || t1) && req.write && req.posted
    |=> res_q.act == CAD_ACT_DROP) else $error("posted configuration write not dropped");
  a_up_t0_drop: assert property (!IS_HOST && req_valid && t0 && req.upstream
    |=> res_q.act == CAD_ACT_DROP) else $error("upstream type 0 not dropped");
  a_unclaimed_dev: assert property (!IS_HOST && plain && (t0 || x0) && req.src_unit == 5'h00
    && out_rng |=> res_q.act == CAD_ACT_UNCLAIMED) else $error("foreign device number claimed");
  a_up_abort: assert property (up_t1 && !cfg.upstream_cfg_en |=> res_q.act == CAD_ACT_ABORT)
    else $error("upstream access not aborted while disabled");
  a_reflect_t0: assert property (up_t1 && cfg.upstream_cfg_en && req.addr[23:16] == cfg.chain_bus
    && req.addr[15:11] < cfg.host_dev_num |=> res_q.act == CAD_ACT_REFLECT
    && res_q.new_addr[63:24] == `CAD_PFX_T0) else $error("local chain access not reflected");
  a_flat_xlate: assert property (IS_HOST && sw_valid |=> pkt_valid_q
    && pkt_q.addr[23:8] == {$past(sw_addr[27:20]), $past(sw_addr[19:15]), $past(sw_addr[14:12])})
    else $error("flat address fields misplaced");
  a_dev_no_pkt: assert property (!IS_HOST |-> !pkt_valid_q)
    else $error("device produced a translated packet");
endmodule : cad_config_decode_asserts
bind cad_config_decode cad_config_decode_asserts #(.IS_HOST(IS_HOST)) cad_config_decode_asserts_inst (
  .clk(clk), .rst(rst), .cfg(cfg), .req_valid(req_valid), .req(req), .sw_valid(sw_valid),
  .sw_addr(sw_addr), .res_valid_q(res_valid_q), .res_q(res_q), .pkt_valid_q(pkt_valid_q),
  .pkt_q(pkt_q));
`default_nettype wire

// [verif/cad_chain_peer.sv]
// Behavioural chain peer that issues sized configuration requests
`default_nettype none
`include "cad_defs.svh"
module cad_chain_peer (
  // Clock
  input wire logic clk,
  // Request towards the decoder
  output logic req_valid,
  output cad_pkg::cad_req_type req
);
  timeunit 1ns;
  timeprecision 1ps;
  import cad_pkg::*;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // Valid stays up between back-to-back calls; a gap withdraws it and inverts the held address
  task automatic issue(input cad_kind_type kind, input logic [23:0] low, input logic [3:0] ureg,
      input cad_req_type attr, input int gap);
    logic [63:0] a;
    a = {40'h0, low};
    case (kind)
      CAD_KIND_T0: a[63:24] = `CAD_PFX_T0;
      CAD_KIND_T1: a[63:24] = `CAD_PFX_T1;
      CAD_KIND_XT0: a[63:24] = {`CAD_XPFX_T0, ureg};
      CAD_KIND_XT1: a[63:24] = {`CAD_XPFX_T1, ureg};
      default: a[63:24] = {8'h5A, 32'($urandom())};
    endcase
    if (gap > 0) begin
      req_valid <= 1'b0;
      req.addr <= ~req.addr;
      repeat (gap) @(negedge clk);
    end
    attr.addr = a;
    req <= attr;
    req_valid <= 1'b1;
    @(negedge clk);
  endtask : issue
  // Withdraws valid so a held request is not taken again while the bench drains
  task automatic idle(input int n);
    req_valid <= 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
endmodule : cad_chain_peer
`default_nettype wire

// [verif/config_access_decode_test.sv]
// Self-checking bench for the configuration access decoder
`default_nettype none
`include "cad_defs.svh"
module config_access_decode_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cad_pkg::*;
  logic clk, rst, vd, vh, rvd, rvh, pvh, badd, badh, sw_valid, sw_write;
  logic [27:0] sw_addr;
  logic [7:0] busd, bush, rb;
  cad_cfg_type cfg_d, cfg_h;
  cad_req_type rd, rh;
  cad_res_type resd, resh;
  cad_pkt_type pkh;
  int fail_count, check_count;
  cad_act_type qd[$], qh[$];
  logic [65:0] qp[$];
  cad_chain_peer peer_dev (.clk(clk), .req_valid(vd), .req(rd));
  cad_chain_peer peer_host (.clk(clk), .req_valid(vh), .req(rh));
  cad_config_decode #(.IS_HOST(1'b0)) cad_config_decode_inst (.clk(clk), .rst(rst), .cfg(cfg_d),
    .req_valid(vd), .req(rd), .sw_valid(sw_valid), .sw_addr(sw_addr), .sw_write(sw_write),
    .res_valid_q(rvd), .res_q(resd), .pkt_valid_q(), .pkt_q(), .bus_num_q(busd), .cfg_bad_q(badd));
  cad_config_decode #(.IS_HOST(1'b1)) cad_config_decode_inst_host (.clk(clk), .rst(rst),
    .cfg(cfg_h), .req_valid(vh), .req(rh), .sw_valid(sw_valid), .sw_addr(sw_addr),
    .sw_write(sw_write), .res_valid_q(rvh), .res_q(resh), .pkt_valid_q(pvh), .pkt_q(pkh),
    .bus_num_q(bush), .cfg_bad_q(badh));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [65:0] seen, input logic [65:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  function automatic logic [23:0] lo(input logic [4:0] d, input logic [5:0] r);
    return {rb, d, 3'(d), r, 2'b00};
  endfunction : lo
  function automatic cad_req_type at(input logic wr, pst, input logic [3:0] len, input logic up,
      input logic [4:0] src);
    return {64'h0, wr, pst, len, up, src};
  endfunction : at
  task automatic send(input bit host, input cad_kind_type k, input logic [23:0] low,
      input cad_req_type attr, input int gap, input cad_act_type want);
    if (host) begin
      qh.push_back(want);
      peer_host.issue(k, low, 4'hA, attr, gap);
    end else begin
      qd.push_back(want);
      peer_dev.issue(k, low, 4'hA, attr, gap);
    end
  endtask : send
  task automatic flat(input logic [27:0] fa, input logic wr, input logic ext,
      input logic [63:0] pa);
    qp.push_back({pa, wr, ext});
    sw_addr <= fa;
    sw_write <= wr;
    sw_valid <= 1'b1;
    @(negedge clk);
  endtask : flat
  // Results are paired with the oldest note once the edge's updates have landed
  always @(posedge clk) begin
    #1;
    if (rvd === 1'b1) check(resd.act, qd.pop_front(), "device act");
    if (rvh === 1'b1) check(resh.act, qh.pop_front(), "host act");
    if (pvh === 1'b1) check(pkh, qp.pop_front(), "flat packet");
  end
  initial begin
    rst = 1'b1;
    {sw_valid, sw_write, sw_addr} = '0;
    cfg_d = {5'h04, 6'h03, 32'h00000050, 5'h00, 1'b0, 1'b0, 8'h00};
    cfg_h = {5'h00, 6'h00, 32'h00000000, 5'h1E, 1'b1, 1'b1, 8'h03};
    void'($urandom(6));
    rb = 8'($urandom());
    fork
      begin
        #200us;
        fail_count++;
        conclude();
      end
    join_none
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int d = 3; d < 8; d++) begin
      send(0, CAD_KIND_T0, lo(5'(d), 6'($urandom())), at(1'(d), 0, 0, 0, 0), 0,
        (d == 4 || d == 6) ? CAD_ACT_ACCEPT : CAD_ACT_UNCLAIMED);
    end
    send(0, CAD_KIND_T0, lo(5'h04, 6'h01), at(0, 0, 0, 1, 0), 0, CAD_ACT_DROP);
    send(0, CAD_KIND_T0, lo(5'h04, 6'h01), at(0, 0, 0, 0, 2), 0, CAD_ACT_DROP);
    send(0, CAD_KIND_T1, lo(5'h09, 6'h02), at(0, 0, 0, 0, 0), 2, CAD_ACT_FORWARD);
    send(0, CAD_KIND_XT0, lo(5'h04, 6'h3F), at(1, 0, 0, 0, 0), 0, CAD_ACT_ACCEPT);
    send(0, CAD_KIND_XT1, lo(5'h04, 6'h00), at(0, 0, 0, 0, 0), 0, CAD_ACT_FORWARD);
    send(0, CAD_KIND_XT0, lo(5'h04, 6'h00), at(1, 1, 0, 0, 0), 0, CAD_ACT_MESSAGE);
    send(0, CAD_KIND_T0, lo(5'h04, 6'h00), at(0, 0, 1, 0, 0), 0, CAD_ACT_DROP);
    send(0, CAD_KIND_T0, lo(5'h04, 6'h00), at(1, 1, 0, 0, 0), 0, CAD_ACT_DROP);
    send(0, CAD_KIND_NONE, lo(5'h04, 6'h00), at(0, 0, 0, 0, 0), 0, CAD_ACT_NONE);
    peer_dev.idle(3);
    check(busd, rb, "learned bus");
    check({badd, badh}, 2'b00, "config status");
    $display("device tests done");
    rb = 8'h03;
    send(1, CAD_KIND_T0, lo(5'h1E, 6'h00), at(0, 0, 0, 0, 0), 0, CAD_ACT_ACCEPT);
    send(1, CAD_KIND_T0, lo(5'h02, 6'h00), at(0, 0, 0, 0, 0), 0, CAD_ACT_UNCLAIMED);
    send(1, CAD_KIND_T1, lo(5'h02, 6'h00), at(0, 0, 0, 0, 0), 0, CAD_ACT_FORWARD);
    send(1, CAD_KIND_T1, lo(5'h02, 6'h04), at(1, 0, 0, 1, 2), 0, CAD_ACT_REFLECT);
    send(1, CAD_KIND_T1, lo(5'h1F, 6'h04), at(0, 0, 0, 1, 2), 0, CAD_ACT_ACCEPT);
    rb = 8'h09;
    send(1, CAD_KIND_T1, lo(5'h02, 6'h04), at(0, 0, 0, 1, 2), 0, CAD_ACT_ABORT);
    peer_host.idle(2);
    cfg_h.upstream_cfg_en = 1'b0;
    rb = 8'h03;
    send(1, CAD_KIND_T1, lo(5'h02, 6'h04), at(0, 0, 0, 1, 2), 2, CAD_ACT_ABORT);
    peer_host.idle(0);
    flat({8'h03, 5'h02, 3'h1, 10'h005, 2'b00}, 1'b1, 1'b0, {`CAD_PFX_T0, 24'h031114});
    flat({8'h07, 5'h02, 3'h1, 10'h145, 2'b00}, 1'b0, 1'b1,
      {`CAD_XPFX_T1, 4'h5, 24'h071114});
    sw_valid <= 1'b0;
    peer_host.idle(3);
    check(bush, 8'h03, "host learned bus");
    check(qd.size() + qh.size() + qp.size(), 0, "results owed");
    $display("host tests done");
    conclude();
  end
endmodule : config_access_decode_test
`default_nettype wire
